//--- psr_pkg.sv
// Purpose: Shared constants for the printer serial receive port
// Assumes: 100 MHz MCLK
// Notes:   Bit rates and buffer thresholds are fixed by the port
package psr_pkg;
  localparam int          CLK_HZ      = 100000000;
  localparam int          OVERSAMPLE  = 16;
  localparam int          BAUD_1200   = 1200;
  localparam int          BAUD_4800   = 4800;
  localparam int          BAUD_9600   = 9600;
  localparam int          BAUD_19200  = 19200;
  localparam int          BUF_DEPTH   = 64;
  localparam int          PTR_W       = 6;
  localparam int          CNT_W       = 7;
  localparam logic [6:0]  XOFF_FREE   = 7'h0A;  // Below 10 free bytes
  localparam logic [6:0]  XON_FREE    = 7'h14;  // Above 20 free bytes
  localparam logic [7:0]  CODE_XOFF   = 8'h13;
  localparam logic [7:0]  CODE_XON    = 8'h11;
  localparam logic [7:0]  CODE_QMARK  = 8'h3F;
  localparam logic [3:0]  MID_SAMPLE  = 4'h7;
  localparam logic [3:0]  LAST_SAMPLE = 4'hF;
  // Switch bank bit positions
  localparam int          SW_SOFTFLOW = 0;
  localparam int          SW_PAR_EN   = 1;
  localparam int          SW_PAR_EVEN = 2;
  localparam int          SW_SEVEN    = 3;
  localparam int          SW_BAUD_LO  = 4;
  localparam int          SW_BAUD_HI  = 5;
  localparam int          SW_DISCARD  = 6;
  localparam logic [2:0]  INT_FRAME   = 3'h1;
  localparam logic [2:0]  INT_OVERRUN = 3'h2;
  localparam logic [2:0]  INT_PARITY  = 3'h4;
  // APB register byte addresses
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MASK   = 12'h004;
  localparam logic [11:0] ADDR_DATA   = 12'h008;
  localparam logic [11:0] ADDR_TXSTAT = 12'h00C;
  localparam logic [11:0] ADDR_LEVEL  = 12'h010;
  localparam logic [11:0] ADDR_CONFIG = 12'h014;
endpackage : psr_pkg

//--- psr_serial_port.sv
// Purpose: Serial receive port with DTR/DSR or Xon/Xoff flow control
// Assumes: Switch bank and pins are asynchronous; one 100 MHz clock
// Notes:   Printer logic drains the buffer over APB; status bytes written over APB, sent on TXD
//
// Operation
// - Bit rate is one of 1200, 4800, 9600 or 19200, same at both ends.
// - Frames carry seven or eight data bits by setting.
// - Parity odd, even or none, by enable and even/odd settings.
// - Flow control is either DTR/DSR handshake or Xon/Xoff, by setting.
// - Errored characters are discarded or replaced by '?' per policy.
// - Host sends only while DTR ready; a character during busy in hardware mode is overrun, then dropped or replaced by '?' per policy.
// - Reception continues into the buffer regardless of print engine busy.
// - Software mode sends Xoff 13H when free space falls below 10 bytes.
// - Software mode sends Xon 11H when free space rises above 20 bytes.
// - Hardware mode holds status bytes until DSR is at space.
// - Software mode sends status bytes regardless of DSR.
// - Hardware mode drives DTR space when accepting, mark when not.
// - Settings are captured once after reset and never again.
`timescale 1ns/100ps
`default_nettype none
module psr_serial_port
  import psr_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic [7:0]  CFG_SWITCH,
  input  wire logic        RXD,
  input  wire logic        DSR,
  output logic             TXD,
  output logic             DTR,
  output logic             IRQ,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} psr_rx_e;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} psr_tx_e;

  // Tick period for sixteen samples per bit, rounded down
  function automatic logic [15:0] tick_div(input logic [1:0] sel);
    int rate;
    case (sel)
      2'h0:    rate = BAUD_1200;
      2'h1:    rate = BAUD_4800;
      2'h2:    rate = BAUD_9600;
      default: rate = BAUD_19200;
    endcase
    tick_div = 16'(CLK_HZ / (rate * OVERSAMPLE));
  endfunction : tick_div

  // Parity over the active data bits
  function automatic logic par_of(input logic [7:0] d, input logic seven, input logic even);
    logic p;
    p = ^(seven ? {1'b0, d[6:0]} : d);
    par_of = even ? p : ~p;
  endfunction : par_of

  // Two-stage synchronisers for pins and switches
  logic [1:0] rxd_s_q;
  logic [1:0] dsr_s_q;
  logic [7:0] sw_s1_q;
  logic [7:0] sw_s2_q;
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      rxd_s_q <= 2'h3;
      dsr_s_q <= 2'h3;
      sw_s1_q <= 8'h00;
      sw_s2_q <= 8'h00;
    end
    else
    begin
      rxd_s_q <= {rxd_s_q[0], RXD};
      dsr_s_q <= {dsr_s_q[0], DSR};
      sw_s1_q <= CFG_SWITCH;
      sw_s2_q <= sw_s1_q;
    end
  wire rxd = rxd_s_q[1];
  wire dsr_space = ~dsr_s_q[1];

  // Settings latched once after reset; later switch changes are ignored
  logic [7:0] cfg_q;
  logic [1:0] cfg_cnt_q;
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      cfg_q     <= 8'h00;
      cfg_cnt_q <= 2'h0;
    end
    else if (cfg_cnt_q != 2'h3)
    begin
      cfg_cnt_q <= cfg_cnt_q + 2'h1;
      if (cfg_cnt_q == 2'h2)
        cfg_q <= sw_s2_q;
    end
  wire cfg_ok    = (cfg_cnt_q == 2'h3);
  wire soft_flow = cfg_q[SW_SOFTFLOW];
  wire par_en    = cfg_q[SW_PAR_EN];
  wire par_even  = cfg_q[SW_PAR_EVEN];
  wire seven     = cfg_q[SW_SEVEN];
  wire discard   = cfg_q[SW_DISCARD];
  wire [3:0] nbits = seven ? 4'h7 : 4'h8;

  // Sixteen-times tick, shared by receiver and transmitter
  logic [15:0] div_q;
  logic        tick_q;
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (div_q >= tick_div(cfg_q[SW_BAUD_HI:SW_BAUD_LO]) - 16'h0001)
      begin
        div_q  <= 16'h0000;
        tick_q <= cfg_ok;
      end
      else
        div_q <= div_q + 16'h0001;
    end

  // Input buffer storage and level
  logic [7:0]       buf_mem [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] level_q;
  wire [CNT_W-1:0]  free_cnt = CNT_W'(BUF_DEPTH) - level_q;
  wire              buf_full = (level_q == CNT_W'(BUF_DEPTH));

  // Receiver: centre sampling at count seven of sixteen
  psr_rx_e    rx_st_q;
  logic [3:0] rx_ph_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic       rx_perr_q;
  logic       rx_done_q;
  logic       rx_ferr_q;
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      rx_st_q   <= RX_IDLE;
      rx_ph_q   <= 4'h0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_perr_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
    end
    else
    begin
      rx_done_q <= 1'b0;
      if (tick_q)
      begin
        rx_ph_q <= rx_ph_q + 4'h1;
        case (rx_st_q)
          RX_IDLE:
            if (!rxd)
            begin
              rx_st_q <= RX_START;
              rx_ph_q <= 4'h0;
            end
          RX_START:
            if (rx_ph_q == MID_SAMPLE)
            begin
              rx_ph_q  <= 4'h0;
              rx_bit_q <= 4'h0;
              rx_sh_q  <= 8'h00;
              rx_st_q  <= rxd ? RX_IDLE : RX_DATA; // glitch rejected
            end
          RX_DATA:
            if (rx_ph_q == LAST_SAMPLE)
            begin
              rx_sh_q[rx_bit_q[2:0]] <= rxd;
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == nbits - 4'h1)
                rx_st_q <= par_en ? RX_PAR : RX_STOP;
            end
          RX_PAR:
            if (rx_ph_q == LAST_SAMPLE)
            begin
              rx_perr_q <= (rxd != par_of(rx_sh_q, seven, par_even));
              rx_st_q   <= RX_STOP;
            end
          RX_STOP:
            if (rx_ph_q == LAST_SAMPLE)
            begin
              rx_ferr_q <= ~rxd;
              rx_done_q <= 1'b1;
              rx_st_q   <= RX_IDLE;
              if (!par_en)
                rx_perr_q <= 1'b0;
            end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
    end

  // Receive gate; DTR and Xoff say busy well before the buffer is full
  logic busy_q;
  wire  overrun = rx_done_q & (buf_full | (~soft_flow & busy_q));
  wire  rx_err  = rx_ferr_q | rx_perr_q | overrun;
  wire  push    = rx_done_q & ~buf_full & ~(rx_err & discard);
  wire  [7:0] push_data = rx_err ? CODE_QMARK : rx_sh_q;

  // APB decode
  wire  apb_acc = PSEL & PENABLE;
  wire  apb_wr  = apb_acc & PWRITE;
  wire  pop     = apb_acc & ~PWRITE & (PADDR == ADDR_DATA) & (level_q != '0);
  logic tx_req_q;
  logic [7:0] tx_stat_q;

  // Buffer write and read pointers
  always_ff @(posedge MCLK)
    if (push)
      buf_mem[wr_ptr_q] <= push_data;
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + PTR_W'(1);
      if (pop)
        rd_ptr_q <= rd_ptr_q + PTR_W'(1);
      level_q <= level_q + CNT_W'(push) - CNT_W'(pop);
    end

  // Busy with hysteresis: set below 10 free, clear above 20 free
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
      busy_q <= 1'b0;
    else if (free_cnt < XOFF_FREE)
      busy_q <= 1'b1;
    else if (free_cnt > XON_FREE)
      busy_q <= 1'b0;

  // DTR is mark (1) while busy in hardware mode
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
      DTR <= 1'b1;
    else
      DTR <= soft_flow ? 1'b0 : (busy_q | ~cfg_ok);

  // Flow codes pending on busy edges, software mode only
  logic busy_d1_q;
  logic xoff_pend_q;
  logic xon_pend_q;
  psr_tx_e    tx_st_q;
  logic [3:0] tx_ph_q;
  logic [3:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic       tx_par_q;
  wire  tx_free  = (tx_st_q == TX_IDLE) & tx_ph_q == 4'h0;
  wire  tx_go_fl = tx_free & (xoff_pend_q | xon_pend_q);
  wire  tx_go_st = tx_free & ~tx_go_fl & tx_req_q & (soft_flow | dsr_space);
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      busy_d1_q   <= 1'b0;
      xoff_pend_q <= 1'b0;
      xon_pend_q  <= 1'b0;
    end
    else
    begin
      busy_d1_q <= busy_q;
      if (soft_flow & busy_q & ~busy_d1_q)
      begin
        xoff_pend_q <= 1'b1;
        xon_pend_q  <= 1'b0;
      end
      else if (soft_flow & ~busy_q & busy_d1_q)
      begin
        xon_pend_q  <= 1'b1;
        xoff_pend_q <= 1'b0;
      end
      else if (tx_go_fl)
      begin
        xoff_pend_q <= 1'b0;
        xon_pend_q  <= 1'b0;
      end
    end

  // Transmitter, same frame format as reception
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      tx_st_q  <= TX_IDLE;
      tx_ph_q  <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 8'h00;
      tx_par_q <= 1'b0;
      TXD      <= 1'b1;
    end
    else if (tx_go_fl | tx_go_st)
    begin
      tx_sh_q  <= tx_go_fl ? (xoff_pend_q ? CODE_XOFF : CODE_XON) : tx_stat_q;
      tx_par_q <= par_of(tx_go_fl ? (xoff_pend_q ? CODE_XOFF : CODE_XON) : tx_stat_q, seven, par_even);
      tx_st_q  <= TX_START;
      tx_ph_q  <= 4'h0;
      tx_bit_q <= 4'h0;
    end
    else if (tick_q)
    begin
      tx_ph_q <= tx_ph_q + 4'h1;
      case (tx_st_q)
        TX_IDLE:  TXD <= 1'b1;
        TX_START: TXD <= 1'b0;
        TX_DATA:  TXD <= tx_sh_q[tx_bit_q[2:0]];
        TX_PAR:   TXD <= tx_par_q;
        TX_STOP:  TXD <= 1'b1;
        default:  TXD <= 1'b1;
      endcase
      if (tx_ph_q == LAST_SAMPLE && tx_st_q != TX_IDLE)
        case (tx_st_q)
          TX_START: tx_st_q <= TX_DATA;
          TX_DATA:
          begin
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == nbits - 4'h1)
              tx_st_q <= par_en ? TX_PAR : TX_STOP;
          end
          TX_PAR:  tx_st_q <= TX_STOP;
          default: tx_st_q <= TX_IDLE;
        endcase
      else if (tx_st_q == TX_IDLE)
        tx_ph_q <= 4'h0;
    end

  // Status byte request: set by software write, cleared when sent
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      tx_req_q  <= 1'b0;
      tx_stat_q <= 8'h00;
    end
    else if (apb_wr && PADDR == ADDR_TXSTAT && !tx_req_q)
    begin
      tx_req_q  <= 1'b1;
      tx_stat_q <= PWDATA[7:0];
    end
    else if (tx_go_st)
      tx_req_q <= 1'b0;

  // Sticky error status, write one to clear; a new event wins over the clear
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  wire  [2:0] ev = {rx_done_q & rx_perr_q, overrun, rx_done_q & rx_ferr_q};
  always_ff @(posedge MCLK or posedge RST)
    if (RST)
    begin
      stat_q <= 3'h0;
      mask_q <= 3'h0;
    end
    else
    begin
      stat_q <= (stat_q & ~((apb_wr && PADDR == ADDR_STATUS) ? PWDATA[2:0] : 3'h0)) | ev;
      if (apb_wr && PADDR == ADDR_MASK)
        mask_q <= PWDATA[2:0];
    end
  assign IRQ = |(stat_q & mask_q);

  // Read mux; zero-wait slave, unmapped addresses answer with an error
  logic known;
  always_comb
  begin
    known  = 1'b1;
    PRDATA = 32'h00000000;
    case (PADDR)
      ADDR_STATUS: PRDATA = {29'h0, stat_q};
      ADDR_MASK:   PRDATA = {29'h0, mask_q};
      ADDR_DATA:   PRDATA = {23'h0, level_q == '0, buf_mem[rd_ptr_q]};
      ADDR_TXSTAT: PRDATA = {31'h0, tx_req_q};
      ADDR_LEVEL:  PRDATA = {24'h0, busy_q, level_q};
      ADDR_CONFIG: PRDATA = {24'h0, cfg_q};
      default:     known  = 1'b0;
    endcase
  end
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_acc & ~known;

  // Checks
  overrun_drop_a: assert property (@(posedge MCLK) disable iff (RST)
    (rx_done_q && !soft_flow && busy_q && discard) |=> $stable(wr_ptr_q))
    else $error("Char during busy was stored");
  dtr_mark_a: assert property (@(posedge MCLK) disable iff (RST)
    (!soft_flow && cfg_ok && busy_q) |=> DTR)
    else $error("DTR not mark while busy");
  xoff_send_a: assert property (@(posedge MCLK) disable iff (RST)
    (soft_flow && busy_q && !busy_d1_q && tx_free) |=>
      ((xoff_pend_q && tx_sh_q != CODE_XON) or (##1 tx_sh_q == CODE_XOFF)))
    else $error("Xoff not queued");
  xon_send_a: assert property (@(posedge MCLK) disable iff (RST)
    (soft_flow && !busy_q && busy_d1_q) |-> ##1 xon_pend_q)
    else $error("Xon not queued");
  dsr_hold_a: assert property (@(posedge MCLK) disable iff (RST)
    (tx_go_st && !soft_flow) |-> dsr_space)
    else $error("Status sent while DSR mark");
  cfg_frozen_a: assert property (@(posedge MCLK) disable iff (RST)
    cfg_ok |=> $stable(cfg_q))
    else $error("Settings changed after capture");
  qmark_sub_a: assert property (@(posedge MCLK) disable iff (RST)
    (push && rx_err) |=> buf_mem[$past(wr_ptr_q)] == CODE_QMARK)
    else $error("Errored char not replaced");
  ferr_flag_a: assert property (@(posedge MCLK) disable iff (RST)
    (rx_done_q && rx_ferr_q) |=> stat_q[0])
    else $error("Framing error not flagged");
  busy_hyst_a: assert property (@(posedge MCLK) disable iff (RST)
    (free_cnt < XOFF_FREE) |=> busy_q)
    else $error("Busy not raised below threshold");
  rx_char_c: cover property (@(posedge MCLK) disable iff (RST) push && !rx_err);
  xoff_c:    cover property (@(posedge MCLK) disable iff (RST) tx_go_fl && xoff_pend_q);
  xon_c:     cover property (@(posedge MCLK) disable iff (RST) tx_go_fl && xon_pend_q);
  status_c:  cover property (@(posedge MCLK) disable iff (RST) tx_go_st);
endmodule : psr_serial_port
`default_nettype wire

//--- psr_host_model.sv
// Purpose: Host computer at the far end of the serial link
// Assumes: 19200 bit/s, seven data bits, even parity, one stop bit
// Notes:   Receiver keeps the last byte seen on TXD and tracks Xon/Xoff
`timescale 1ns/100ps
`default_nettype none
module psr_host_model
  import psr_pkg::*;
#(
  parameter int BIT_CYC = CLK_HZ / BAUD_19200
)
(
  input  wire logic MCLK,
  input  wire logic TXD,
  output logic      RXD
);
  logic [7:0] rx_byte;
  logic       rx_got;
  logic       xoff_seen;

  // Idle line is mark, so the device sees no start bit
  initial
  begin
    RXD       = 1'b1;
    rx_got    = 1'b0;
    xoff_seen = 1'b0;
  end

  // One frame, LSB first; bad_par flips the parity bit on purpose
  task send_char(input logic [6:0] ch, input logic bad_par);
    logic [9:0] f;
    begin
      f = {1'b1, ^ch ^ bad_par, ch, 1'b0};
      wait (!xoff_seen);
      for (int i = 0; i < 10; i++)
      begin
        @(posedge MCLK);
        RXD <= f[i];
        repeat (BIT_CYC - 1) @(posedge MCLK);
      end
    end
  endtask : send_char

  // Sample each bit at its centre; flow codes gate our own sending
  initial
  begin
    logic [9:0] g;
    forever
    begin
      @(negedge TXD);
      repeat (BIT_CYC / 2) @(posedge MCLK);
      // Stop after the stop-bit centre so a back-to-back start edge is not missed
      for (int i = 0; i < 10; i++)
      begin
        g[i] = TXD;
        if (i < 9)
          repeat (BIT_CYC) @(posedge MCLK);
      end
      rx_byte = {1'b0, g[7:1]};
      if (rx_byte == CODE_XOFF) xoff_seen = 1'b1;
      if (rx_byte == CODE_XON) xoff_seen = 1'b0;
      rx_got = 1'b1;
    end
  end
endmodule : psr_host_model
`default_nettype wire

//--- printer_serial_rx_flow_control_test.sv
// Purpose: Self-checking bench for the serial port over APB and the link
// Assumes: Switches set soft flow, even parity, seven bits, 19200; a second power-up uses DTR/DSR
// Notes:   Frames are long at 19200, so only two are sent to keep the run short
`timescale 1ns/100ps
`default_nettype none
module printer_serial_rx_flow_control_test;
  import psr_pkg::*;
  logic        MCLK;
  logic        RST;
  logic [7:0]  CFG_SWITCH;
  logic        RXD;
  logic        DSR;
  logic        TXD;
  logic        DTR;
  logic        IRQ;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [31:0] rd;
  logic        er;
  int          n_fail;
  int          checks_done;
  int          cyc;

  psr_serial_port DUT (.MCLK(MCLK), .RST(RST), .CFG_SWITCH(CFG_SWITCH), .RXD(RXD), .DSR(DSR),
    .TXD(TXD), .DTR(DTR), .IRQ(IRQ), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  psr_host_model host (.MCLK(MCLK), .TXD(TXD), .RXD(RXD));

  // 100 MHz clock
  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask : report_and_stop

  // Cap on the run: two received frames take about 104k cycles, the DTR phase about 1k more
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 110000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask : check

  // One APB transfer; waits for PREADY, takes data at that edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge MCLK);
      PSEL    <= 1'b1;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask : apb

  // Poll the level until a byte lands in the buffer
  task wait_byte;
    begin
      do apb(1'b0, ADDR_LEVEL, 32'h0); while (rd[6:0] === 7'h00);
    end
  endtask : wait_byte

  initial
  begin
    n_fail = 0;
    checks_done = 0;
    cyc = 0;
    RST = 1'b1;
    CFG_SWITCH = 8'h3F;
    DSR = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    repeat (4) @(posedge MCLK);
    check("txd_reset", {31'h0, TXD}, 32'h1);
    check("dtr_reset", {31'h0, DTR}, 32'h1);
    check("irq_reset", {31'h0, IRQ}, 32'h0);
    RST <= 1'b0;
    repeat (6) @(posedge MCLK);
    // Switches move after capture; the captured copy must not follow
    CFG_SWITCH <= 8'h40;
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config", rd, 32'h3F);
    check("pready", {31'h0, PREADY}, 32'h1);
    check("dtr_soft", {31'h0, DTR}, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped_err", {31'h0, er}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status_reset", rd, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h7);
    apb(1'b0, ADDR_MASK, 32'h0);
    check("mask", rd, 32'h7);
    // DSR at mark must not hold a status byte in soft mode
    apb(1'b1, ADDR_TXSTAT, 32'h55);
    // Start bit begins at the next sixteenth-bit tick, up to 325 cycles away
    repeat (400) @(posedge MCLK);
    check("tx_started", {31'h0, TXD}, 32'h0);
    host.send_char(7'h5A, 1'b0);
    wait_byte();
    apb(1'b0, ADDR_DATA, 32'h0);
    check("rx_good", rd, 32'h5A);
    // Parity error turns the byte into a question mark
    host.send_char(7'h21, 1'b1);
    wait_byte();
    apb(1'b0, ADDR_DATA, 32'h0);
    check("rx_bad", rd, {24'h0, CODE_QMARK});
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("parity_flag", rd, {29'h0, INT_PARITY});
    check("irq_set", {31'h0, IRQ}, 32'h1);
    apb(1'b1, ADDR_STATUS, {29'h0, INT_PARITY});
    @(posedge MCLK);
    check("irq_clear", {31'h0, IRQ}, 32'h0);
    apb(1'b0, ADDR_DATA, 32'h0);
    check("empty", {31'h0, rd[8]}, 32'h1);
    wait (host.rx_got === 1'b1);
    check("tx_byte", {24'h0, host.rx_byte}, 32'h55);
    // Second power-up in DTR/DSR mode: status byte waits for DSR space
    @(posedge MCLK);
    RST <= 1'b1;
    CFG_SWITCH <= 8'h3E;
    DSR <= 1'b1;
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    check("dtr_boot", {31'h0, DTR}, 32'h1);
    repeat (6) @(posedge MCLK);
    check("dtr_hw", {31'h0, DTR}, 32'h0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config_hw", rd, 32'h3E);
    apb(1'b1, ADDR_TXSTAT, 32'h5A);
    repeat (400) @(posedge MCLK);
    check("tx_held", {31'h0, TXD}, 32'h1);
    apb(1'b0, ADDR_TXSTAT, 32'h0);
    check("tx_pending", rd, 32'h1);
    DSR <= 1'b0;
    repeat (400) @(posedge MCLK);
    check("tx_released", {31'h0, TXD}, 32'h0);
    report_and_stop();
  end
endmodule : printer_serial_rx_flow_control_test
`default_nettype wire
